// [ssr_pkg.sv]
// Purpose: shared constants and types of the security transfer decoder
// Assumes: command entries arrive already fetched from the admin queue
// Notes:   register map, status codes, field positions, carrier structs
package ssr_pkg;

    // -----------------------------------------------------------------
    // command fields and protocol codes
    // -----------------------------------------------------------------
    localparam int             SEL_MSB        = 31;
    localparam int             SEL_LSB        = 24;
    localparam int             PSF_MSB        = 23;
    localparam int             PSF_LSB        = 8;
    localparam int             FSF_MSB        = 7;
    localparam int             FSF_LSB        = 0;
    localparam logic [7:0]     PROT_DISCOVERY = 8'h00;
    localparam logic [7:0]     PROT_FAMILY    = 8'hEA;
    localparam logic [15:0]    PSF_RPM        = 16'h0001;

    // -----------------------------------------------------------------
    // completion status codes
    // -----------------------------------------------------------------
    localparam logic [7:0]     ST_SUCCESS     = 8'h00;
    localparam logic [7:0]     ST_BAD_OPCODE  = 8'h01;
    localparam logic [7:0]     ST_BAD_PARAM   = 8'h02;

    // -----------------------------------------------------------------
    // discovery list: 8 header bytes then one byte per protocol
    // -----------------------------------------------------------------
    localparam logic [3:0]     DSC_HDR_BYTES  = 4'h8;
    localparam logic [7:0]     DSC_LIST_LEN   = 8'h02;
    localparam logic [3:0]     DSC_TOTAL      = 4'hA;

    // -----------------------------------------------------------------
    // register offsets and reset values
    // -----------------------------------------------------------------
    localparam logic [7:0]     REG_CTRL       = 8'h00;
    localparam logic [7:0]     REG_MAXLEN     = 8'h04;
    localparam logic [7:0]     REG_STATUS     = 8'h08;
    localparam logic [7:0]     REG_IRQ_STAT   = 8'h0C;
    localparam logic [7:0]     REG_IRQ_CLR    = 8'h10;
    localparam logic [7:0]     REG_IRQ_EN     = 8'h14;
    localparam logic [7:0]     REG_CMD_COUNT  = 8'h18;
    localparam logic [31:0]    CTRL_RST       = 32'h0000_0001;
    localparam logic [31:0]    MAXLEN_RST     = 32'h0000_1000;
    localparam logic [1:0]     IRQ_RST        = 2'h0;
    localparam logic [1:0]     RESP_OKAY      = 2'h0;
    localparam logic [1:0]     RESP_SLVERR    = 2'h2;

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  opcode;
        logic [15:0] cid;
        logic [63:0] prp1;
        logic [63:0] prp2;
        logic [31:0] cdw10;
        logic [31:0] cdw11;
    } ssr_cmd_t;

    typedef struct packed {
        logic        is_send;
        logic [7:0]  protocol_selector;
        logic [15:0] protocol_specific_field;
        logic [7:0]  family_specific_field;
        logic [63:0] prp1;
        logic [63:0] prp2;
        logic [31:0] xfer_len;
    } ssr_eng_req_t;

    typedef struct packed {
        logic [15:0] cid;
        logic [7:0]  status;
    } ssr_cpl_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DECODE, ST_ENG_REQ, ST_ENG_WAIT, ST_DISC, ST_CPL
    } ssr_state_t;

endpackage

// [ssr_top.sv]
// Purpose: decode and run security send and receive admin commands
// Assumes: command fetch, engine and data mover share aclk
// Notes:   registers over AXI4-Lite, one level interrupt output
`timescale 1ns/1ps

// Summary of operation
// - only opcode, pointers and dwords 10 and 11 are decoded; the command id is copied into the completion
// - first pointer gives the host buffer start address
// - second pointer is passed on unchanged to the engine in the request
// - dword 10 bits 31:24 hold the protocol selector
// - receive with an unsupported selector ends with invalid parameter
// - send with a reserved selector ends with invalid parameter
// - dword 10 bits 23:8 hold the protocol specific field
// - dword 10 bits 7:0 are the family field, used only for EAh
// - receive dword 11 is the allocation length in bytes
// - send dword 11 is the transfer length in bytes
// - every finished command posts a completion with its status
// - receive selector 00h returns the supported protocol list
// - selector EAh is accepted by both send and receive
// - under EAh only specific value 0001h is valid, others reserved
// - send results come back only through a later receive
// - receive result state is dropped on reset
module ssr_top #(
    parameter logic [7:0]  OPC_SEND = 8'h01,
    parameter logic [7:0]  OPC_RECV = 8'h02
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  cmd_valid,
    output logic                       cmd_ready,
    input  wire ssr_pkg::ssr_cmd_t     cmd,
    output logic                       cpl_valid,
    input  wire logic                  cpl_ready,
    output ssr_pkg::ssr_cpl_t          cpl,
    output logic                       eng_req_valid,
    input  wire logic                  eng_req_ready,
    output ssr_pkg::ssr_eng_req_t      eng_req,
    input  wire logic                  eng_done,
    input  wire logic [7:0]            eng_status,
    output logic                       dsc_valid,
    input  wire logic                  dsc_ready,
    output logic [7:0]                 dsc_byte,
    output logic                       dsc_last,
    output logic [63:0]                dsc_addr,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic                       irq
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    ssr_pkg::ssr_state_t   state_r;
    ssr_pkg::ssr_cmd_t     cmd_r;
    ssr_pkg::ssr_cpl_t     cpl_r;
    ssr_pkg::ssr_eng_req_t eng_req_r;
    logic                  cmd_ready_r, cpl_valid_r, eng_req_valid_r;
    logic                  dsc_valid_r, dsc_last_r, irq_r;
    logic                  awready_r, wready_r, bvalid_r;
    logic                  arready_r, rvalid_r;
    logic [3:0]            dsc_idx_r, wstrb_r;
    logic [7:0]            dsc_byte_r, status_r, awaddr_r;
    logic [1:0]            irq_stat_r, irq_stat_nxt, irq_en_r;
    logic [1:0]            bresp_r, rresp_r;
    logic [31:0]           ctrl_r, maxlen_r, cmd_count_r;
    logic [31:0]           wdata_r, rdata_r;

    // -----------------------------------------------------------------
    // field decode of the held command
    // -----------------------------------------------------------------
    wire        is_send  = (cmd_r.opcode == OPC_SEND);
    wire        is_recv  = (cmd_r.opcode == OPC_RECV);
    wire [7:0]  sel      = cmd_r.cdw10[ssr_pkg::SEL_MSB:ssr_pkg::SEL_LSB];
    wire [15:0] psf      = cmd_r.cdw10[ssr_pkg::PSF_MSB:ssr_pkg::PSF_LSB];
    wire [7:0]  fsf_raw  = cmd_r.cdw10[ssr_pkg::FSF_MSB:ssr_pkg::FSF_LSB];
    wire        sel_fam  = (sel == ssr_pkg::PROT_FAMILY);
    wire        sel_disc = (sel == ssr_pkg::PROT_DISCOVERY);
    wire [7:0]  fsf      = sel_fam ? fsf_raw : 8'h00;
    wire [31:0] len      = cmd_r.cdw11;

    // selector acceptance per direction
    wire recv_ok  = sel_disc || sel_fam;
    wire send_ok  = sel_fam;
    wire psf_ok   = !sel_fam || (psf == ssr_pkg::PSF_RPM);
    wire sel_bad  = (is_recv && !recv_ok) || (is_send && !send_ok) || !psf_ok;
    wire is_sec   = is_send || is_recv;
    // length bound toward the engine
    wire [31:0] eng_len = (len < maxlen_r) ? len : maxlen_r;

    // -----------------------------------------------------------------
    // discovery byte selection
    // -----------------------------------------------------------------
    wire [3:0]  dsc_limit = (len < {28'h0, ssr_pkg::DSC_TOTAL}) ?
                            len[3:0] : ssr_pkg::DSC_TOTAL;
    wire        dsc_more  = (dsc_idx_r < dsc_limit);
    wire        dsc_hdr   = (dsc_idx_r < ssr_pkg::DSC_HDR_BYTES);
    wire        dsc_cnt   = (dsc_idx_r == 4'h7);
    wire        dsc_first = (dsc_idx_r == ssr_pkg::DSC_HDR_BYTES);
    wire [7:0]  dsc_list  = dsc_first ? ssr_pkg::PROT_DISCOVERY :
                            ssr_pkg::PROT_FAMILY;
    wire [7:0]  dsc_next  = dsc_hdr ? (dsc_cnt ? ssr_pkg::DSC_LIST_LEN :
                            8'h00) : dsc_list;
    wire        dsc_take  = !dsc_valid_r || dsc_ready;
    wire        dsc_end   = (dsc_idx_r + 4'h1 == dsc_limit);
    // handshakes and events
    wire cmd_hs  = cmd_valid && cmd_ready_r;
    wire cpl_hs  = cpl_valid_r && cpl_ready;
    wire ev_done = cpl_hs;
    wire ev_rej  = cpl_hs && ((cpl_r.status == ssr_pkg::ST_BAD_PARAM) ||
                              (cpl_r.status == ssr_pkg::ST_BAD_OPCODE));

    // -----------------------------------------------------------------
    // command sequencer
    // -----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r     <= ssr_pkg::ST_IDLE;
            cmd_ready_r <= 1'b0;
            cmd_r       <= '0;
            status_r    <= ssr_pkg::ST_SUCCESS;
        end else begin
            unique case (state_r)
                ssr_pkg::ST_IDLE: begin
                    if (cmd_hs) begin
                        cmd_r       <= cmd;
                        cmd_ready_r <= 1'b0;
                        state_r     <= ssr_pkg::ST_DECODE;
                    end else begin
                        cmd_ready_r <= ctrl_r[0];
                    end
                end
                ssr_pkg::ST_DECODE: begin
                    if (!is_sec) begin
                        status_r <= ssr_pkg::ST_BAD_OPCODE;
                        state_r  <= ssr_pkg::ST_CPL;
                    end else if (sel_bad) begin
                        status_r <= ssr_pkg::ST_BAD_PARAM;
                        state_r  <= ssr_pkg::ST_CPL;
                    end else if (is_recv && sel_disc) begin
                        status_r <= ssr_pkg::ST_SUCCESS;
                        state_r  <= dsc_limit == 4'h0 ? ssr_pkg::ST_CPL :
                                    ssr_pkg::ST_DISC;
                    end else begin
                        state_r  <= ssr_pkg::ST_ENG_REQ;
                    end
                end
                ssr_pkg::ST_ENG_REQ: begin
                    if (eng_req_ready) state_r <= ssr_pkg::ST_ENG_WAIT;
                end
                ssr_pkg::ST_ENG_WAIT: begin
                    if (eng_done) begin
                        status_r <= eng_status;
                        state_r  <= ssr_pkg::ST_CPL;
                    end
                end
                ssr_pkg::ST_DISC: begin
                    if (dsc_valid_r && dsc_ready && dsc_last_r)
                        state_r <= ssr_pkg::ST_CPL;
                end
                ssr_pkg::ST_CPL: begin
                    if (cpl_hs) state_r <= ssr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // engine request, held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eng_req_valid_r <= 1'b0;
            eng_req_r       <= '0;
        end else if (state_r == ssr_pkg::ST_DECODE && is_sec && !sel_bad &&
                     !(is_recv && sel_disc)) begin
            eng_req_valid_r             <= 1'b1;
            eng_req_r <= '{is_send, sel, psf, fsf, cmd_r.prp1, cmd_r.prp2,
                           eng_len};
        end else if (eng_req_valid_r && eng_req_ready) begin
            eng_req_valid_r <= 1'b0;
        end
    end

    // discovery byte stream toward the host buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dsc_valid_r <= 1'b0;
            dsc_byte_r  <= 8'h00;
            dsc_last_r  <= 1'b0;
            dsc_idx_r   <= 4'h0;
        end else if (state_r != ssr_pkg::ST_DISC) begin
            dsc_idx_r   <= 4'h0;
        end else if (dsc_take && dsc_more) begin
            dsc_valid_r <= 1'b1;
            dsc_byte_r  <= dsc_next;
            dsc_last_r  <= dsc_end;
            dsc_idx_r   <= dsc_idx_r + 4'h1;
        end else if (dsc_valid_r && dsc_ready) begin
            dsc_valid_r <= 1'b0;
            dsc_last_r  <= 1'b0;
        end
    end

    // completion entry, held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpl_valid_r <= 1'b0;
            cpl_r       <= '0;
        end else if (state_r == ssr_pkg::ST_CPL && !cpl_valid_r) begin
            cpl_valid_r <= 1'b1;
            cpl_r.cid   <= cmd_r.cid;
            cpl_r.status <= status_r;
        end else if (cpl_hs) begin
            cpl_valid_r <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // register bus: write side
    // -----------------------------------------------------------------
    wire aw_hs     = s_axi_awvalid && awready_r;
    wire w_hs      = s_axi_wvalid && wready_r;
    wire wr_go     = !awready_r && !wready_r && !bvalid_r;
    wire wr_ctrl   = wr_go && (awaddr_r == ssr_pkg::REG_CTRL);
    wire wr_maxlen = wr_go && (awaddr_r == ssr_pkg::REG_MAXLEN);
    wire wr_clr    = wr_go && (awaddr_r == ssr_pkg::REG_IRQ_CLR) &&
                     wstrb_r[0];
    wire wr_en     = wr_go && (awaddr_r == ssr_pkg::REG_IRQ_EN) &&
                     wstrb_r[0];
    wire wr_known  = (awaddr_r == ssr_pkg::REG_CTRL) ||
                     (awaddr_r == ssr_pkg::REG_MAXLEN) ||
                     (awaddr_r == ssr_pkg::REG_IRQ_CLR) ||
                     (awaddr_r == ssr_pkg::REG_IRQ_EN);
    wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                         {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

    // address and data latches, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= ssr_pkg::RESP_OKAY;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            if (aw_hs) begin
                awaddr_r  <= {s_axi_awaddr[7:2], 2'h0};
                awready_r <= 1'b0;
            end
            if (w_hs) begin
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
                wready_r <= 1'b0;
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_known ? ssr_pkg::RESP_OKAY :
                            ssr_pkg::RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // software-written registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r   <= ssr_pkg::CTRL_RST;
            maxlen_r <= ssr_pkg::MAXLEN_RST;
            irq_en_r <= ssr_pkg::IRQ_RST;
        end else begin
            if (wr_ctrl) ctrl_r <= (ctrl_r & ~wmask) | (wdata_r & wmask);
            if (wr_maxlen) maxlen_r <= (maxlen_r & ~wmask) | (wdata_r & wmask);
            if (wr_en) irq_en_r <= wdata_r[1:0];
        end
    end

    // sticky events: a new event wins over a clear in the same cycle
    assign irq_stat_nxt = (irq_stat_r & ~(wr_clr ? wdata_r[1:0] : 2'h0)) |
                          {ev_rej, ev_done};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r  <= ssr_pkg::IRQ_RST;
            irq_r       <= 1'b0;
            cmd_count_r <= 32'h0000_0000;
        end else begin
            irq_stat_r  <= irq_stat_nxt;
            irq_r       <= |(irq_stat_nxt & irq_en_r);
            if (ev_done) cmd_count_r <= cmd_count_r + 32'h0000_0001;
        end
    end

    // -----------------------------------------------------------------
    // register bus: read side
    // -----------------------------------------------------------------
    wire [7:0]  raddr   = {s_axi_araddr[7:2], 2'h0};
    wire        ar_hs   = s_axi_arvalid && arready_r;
    wire [31:0] st_word = {8'h00, sel, status_r,
                           7'h00, (state_r != ssr_pkg::ST_IDLE)};
    wire        rd_ok   = (raddr <= ssr_pkg::REG_CMD_COUNT); // word map
    wire [31:0] rd_word =
        (raddr == ssr_pkg::REG_CTRL)      ? ctrl_r :
        (raddr == ssr_pkg::REG_MAXLEN)    ? maxlen_r :
        (raddr == ssr_pkg::REG_STATUS)    ? st_word :
        (raddr == ssr_pkg::REG_IRQ_STAT)  ? {30'h0, irq_stat_r} :
        (raddr == ssr_pkg::REG_IRQ_EN)    ? {30'h0, irq_en_r} :
        (raddr == ssr_pkg::REG_CMD_COUNT) ? cmd_count_r : 32'h0000_0000;

    // read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= ssr_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_word;
            rresp_r   <= rd_ok ? ssr_pkg::RESP_OKAY : ssr_pkg::RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign cmd_ready     = cmd_ready_r;
    assign cpl_valid     = cpl_valid_r;
    assign cpl           = cpl_r;
    assign eng_req_valid = eng_req_valid_r;
    assign eng_req       = eng_req_r;
    assign dsc_valid     = dsc_valid_r;
    assign dsc_byte      = dsc_byte_r;
    assign dsc_last      = dsc_last_r;
    assign dsc_addr      = cmd_r.prp1;
    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign irq           = irq_r;

endmodule

// [ssr_top_chk.sv]
// Purpose: port checks. Assumes: one clock. Notes: bound to ssr_top
`timescale 1ns/1ps
module ssr_top_chk #(parameter logic [7:0] OPC_SEND = 8'h01,
    parameter logic [7:0] OPC_RECV = 8'h02) (
    input wire logic aclk, aresetn, cmd_valid, cmd_ready,
    input wire ssr_pkg::ssr_cmd_t cmd,
    input wire logic cpl_valid, cpl_ready, eng_req_valid, eng_req_ready,
    input wire ssr_pkg::ssr_cpl_t cpl,
    input wire ssr_pkg::ssr_eng_req_t eng_req,
    input wire logic dsc_valid,
    input wire logic [7:0] dsc_byte);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // selector and replay-protected access decode of the offered entry
    wire logic [7:0] sel = cmd.cdw10[31:24];
    wire logic rpm = sel == 8'hEA && cmd.cdw10[23:8] == 16'h0001;
    sequence s_take; cmd_valid && cmd_ready; endsequence
    sequence s_bad; ##[1:4] cpl_valid && cpl.status == 8'h02; endsequence
    property p_rej_send; s_take ##0 (cmd.opcode == OPC_SEND && !rpm) |-> s_bad;
    endproperty
    a_rej_send: assert property (p_rej_send) else $error("send kept");
    property p_rej_recv;
        s_take ##0 (cmd.opcode == OPC_RECV && sel != 8'h00 && !rpm) |-> s_bad;
    endproperty
    a_rej_recv: assert property (p_rej_recv) else $error("recv kept");
    property p_disc; s_take ##0 (cmd.opcode == OPC_RECV && sel == 8'h00 &&
        cmd.cdw11 != 0) |-> ##[1:4] dsc_valid && dsc_byte == 8'h00; endproperty
    a_disc: assert property (p_disc) else $error("no list");
    property p_eng; s_take ##0 (cmd.opcode == OPC_SEND && rpm) |->
        ##[1:4] eng_req_valid && eng_req.is_send; endproperty
    a_eng: assert property (p_eng) else $error("no engine request");
    property p_sel; eng_req_valid |-> eng_req.protocol_selector == 8'hEA &&
        eng_req.protocol_specific_field == 16'h0001; endproperty
    a_sel: assert property (p_sel) else $error("bad engine selector");
    property p_eng_hold; eng_req_valid && !eng_req_ready |=>
        eng_req_valid && $stable(eng_req); endproperty
    a_eng_hold: assert property (p_eng_hold) else $error("req moved");
    property p_cpl_hold;
        cpl_valid && !cpl_ready |=> cpl_valid && $stable(cpl); endproperty
    a_cpl_hold: assert property (p_cpl_hold) else $error("cpl moved");
    property p_busy; s_take |=> !cmd_ready; endproperty
    a_busy: assert property (p_busy) else $error("second take");
endmodule
bind ssr_top ssr_top_chk #(.OPC_SEND(OPC_SEND), .OPC_RECV(OPC_RECV))
    ssr_top_chk_i (.aclk(aclk), .aresetn(aresetn), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .cpl_valid(cpl_valid),
    .cpl_ready(cpl_ready), .cpl(cpl), .eng_req_valid(eng_req_valid),
    .eng_req_ready(eng_req_ready), .eng_req(eng_req),
    .dsc_valid(dsc_valid), .dsc_byte(dsc_byte));

// [ssr_eng_model.sv]
// Purpose: protocol engine. Assumes: one request at a time. Notes: lat sets pace
`timescale 1ns/1ps
module ssr_eng_model (
    input  wire logic       aclk, aresetn, req_valid,
    output logic            req_ready, done,
    output logic [7:0]      status,
    input  wire logic [7:0] lat);
    int cnt;
    // accept, run lat + 2 cycles, then pulse done with success
    always @(posedge aclk) begin
        done <= 1'b0;
        req_ready <= 1'b0;
        status <= ~status;
        if (!aresetn) cnt = 0;
        else if (cnt > 0) begin
            cnt = cnt - 1;
            done <= cnt == 0;
            if (cnt == 0) status <= 8'h00;
        end else if (req_valid && !req_ready) begin
            req_ready <= 1'b1;
            cnt = lat + 2;
        end
    end
endmodule

// [test_security_send_receive_decode.sv]
// Purpose: decoder bench. Assumes: seed fixed. Notes: engine is a model
`timescale 1ns/1ps
module test_security_send_receive_decode;
    logic aclk = 0, aresetn = 0, cmd_valid = 0, cpl_ready = 0, dsc_ready = 0;
    logic awv = 0, wv = 0, arv = 0;
    logic [7:0] aw = 0, ar = 0, lat = 0;
    logic [31:0] wd = 0, mx = 32'h1000, r;
    int seed = 76815, errors = 0, n_tests = 0, cyc = 0, i;
    ssr_pkg::ssr_cmd_t cmd = '0;
    wire logic cmd_ready, cpl_valid, erv, rq_rdy, done, dsc_valid, dsc_last;
    wire logic awr, wrdy, bv, arr, rv, irq;
    wire ssr_pkg::ssr_cpl_t cpl;
    wire ssr_pkg::ssr_eng_req_t er;
    wire logic [7:0] es, db;
    wire logic [1:0] br, rrw;
    wire logic [31:0] rdw;
    wire logic [63:0] da;
    ssr_top ssr_top_i (.aclk(aclk), .aresetn(aresetn), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .cpl_valid(cpl_valid),
        .cpl_ready(cpl_ready), .cpl(cpl), .eng_req_valid(erv),
        .eng_req_ready(rq_rdy), .eng_req(er), .eng_done(done),
        .eng_status(es), .dsc_valid(dsc_valid), .dsc_ready(dsc_ready),
        .dsc_byte(db), .dsc_last(dsc_last), .dsc_addr(da), .s_axi_awaddr(aw),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
        .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdw), .s_axi_rresp(rrw), .s_axi_rvalid(rv),
        .s_axi_rready(1'b1), .irq(irq));
    ssr_eng_model ssr_eng_model_i (.aclk(aclk), .aresetn(aresetn),
        .req_valid(erv), .req_ready(rq_rdy), .done(done), .status(es),
        .lat(lat));
    always #10 aclk = ~aclk;
    task automatic chk(input logic [255:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("comparisons %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_of_test();
        end
    end
    function automatic logic [7:0] dexp(input int k);
        return k == 7 ? 8'h02 : k == 9 ? 8'hEA : 8'h00;
    endfunction
    function automatic logic [7:0] stx(input logic [7:0] op, s, logic [15:0] p);
        if (op != 8'h01 && op != 8'h02) return 8'h01;
        if (op == 8'h02 && s == 8'h00) return 8'h00;
        return (s == 8'hEA && p == 16'h0001) ? 8'h00 : 8'h02;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw;
        pa = 1;
        pw = 1;
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (pa || pw) begin
            @(posedge aclk);
            pa = pa && !awr;
            pw = pw && !wrdy;
            awv <= pa;
            wv <= pw;
        end
        do @(posedge aclk); while (!bv);
        chk(br, 2'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, logic [1:0] e);
        ar <= a;
        arv <= 1'b1;
        do @(posedge aclk); while (!arr);
        arv <= 1'b0;
        do @(posedge aclk); while (!rv);
        chk({rdw, rrw}, {ed, e});
    endtask
    task automatic run(input logic [7:0] op, s, logic [15:0] p, logic [31:0] n);
        int k;
        logic [63:0] p1, p2;
        logic [7:0] f;
        p1 = {$random(seed), $random(seed)};
        p2 = {$random(seed), $random(seed)};
        f = 8'($random(seed));
        k = 0;
        lat <= {5'h0, 3'($random(seed))};
        cmd <= {op, p1[15:0], p1, p2, s, p, f, n};
        cmd_valid <= 1'b1;
        do @(posedge aclk); while (!cmd_ready);
        cmd_valid <= 1'b0;
        do begin
            @(posedge aclk);
            if (dsc_valid && dsc_ready) begin
                chk({db, dsc_last, da}, {dexp(k), 32'(k + 1) == n || k == 9, p1});
                k++;
            end
            if (erv && rq_rdy) chk(er, {op == 8'h01, s, p, f, p1, p2, n < mx ? n : mx});
            cpl_ready <= 1'($random(seed));
            dsc_ready <= 1'($random(seed));
        end while (!(cpl_valid && cpl_ready));
        chk(cpl, {p1[15:0], stx(op, s, p)});
        chk(k, op == 8'h02 && s == 8'h00 ? (n < 10 ? n : 10) : 0);
    endtask
    // main sequence: registers, corner commands, interrupt, random mix
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00, 32'h1, 2'h0);
        rd(8'h04, 32'h1000, 2'h0);
        rd(8'h40, 32'h0, 2'h2);
        wr(8'h04, 32'h40);
        mx = 32'h40;
        run(8'h02, 8'h00, 16'h0, 32'h3);
        run(8'h02, 8'h00, 16'h0, 32'h0);
        run(8'h02, 8'h00, 16'h0, 32'h20);
        run(8'h01, 8'h00, 16'h0, 32'h8);
        run(8'h01, 8'hEA, 16'h0001, 32'h41);
        run(8'h02, 8'hEA, 16'h0002, 32'h4);
        run(8'h02, 8'hEA, 16'h0001, 32'h3F);
        run(8'h05, 8'hEA, 16'h0001, 32'h1);
        chk(irq, 1'b0);
        wr(8'h14, 32'h3);
        rd(8'h0C, 32'h3, 2'h0);
        chk(irq, 1'b1);
        wr(8'h10, 32'h3);
        rd(8'h0C, 32'h0, 2'h0);
        chk(irq, 1'b0);
        for (i = 0; i < 30; i++) begin
            r = $random(seed);
            run(r[1:0] == 2'h3 ? r[9:2] : {7'h0, r[0]} + 8'h01,
                r[3:2] == 2'h0 ? 8'h00 : r[3:2] == 2'h1 ? r[15:8] : 8'hEA,
                r[4] ? 16'h0001 : r[31:16], r[5] ? {29'h0, r[8:6]} * 3 : r);
        end
        end_of_test();
    end
endmodule
